/* File: common/isc_pkg.sv */
// How it works
// RULE1 - standby request with select 00 in normal operation enters light idle
// RULE2 - standby request with select 10 in normal operation enters deep idle
// RULE3 - light idle keeps oscillator, pll, flash; stops cpu and peripheral clocks
// RULE4 - deep idle keeps only oscillator; stops cpu, pll, flash, peripherals
// RULE5 - idle keeps ram and internal data; subclock or external peripherals run
// RULE6 - leaving light idle resumes at once, no stabilization wait
// RULE7 - wake request pending at entry enters idle then leaves at once
// RULE8 - nmi, watchdog nmi, external irqs, peripheral irqs or reset end idle
// RULE9 - a set wake mask bit stops that request class ending idle
// RULE10 - external irq three cannot wake while its filter samples slowly
// RULE11 - lower-priority request inside a handler wakes but stays unacknowledged
// RULE12 - higher-priority or nmi request inside a handler wakes and is acknowledged
// RULE13 - nmi vectors; maskable vectors only when enabled, else next instruction
// RULE14 - deep idle interrupt wake waits the selected timer period first
// RULE15 - a reset wake acts as normal reset with 2^16 cycle wait
// RULE16 - leaving deep idle returns the pll to its pre-entry state
// RULE17 - converter holds operation and result during idle
// RULE18 - dma, timers, intc stop; ports hold; key interrupt and watchdog run
// RULE19 - watch and interval timers run in idle only on allowed sources
// RULE20 - clocked serial ports need external clock; async port zero likewise
// RULE21 - cpu follows the entry write with five or more no-operations
// RULE22 - control register writes only after the protection command write
// RULE23 - both registers reset to 00h; select 01 and 11 mean stop mode
// RULE24 - on wake, idle state clears and clocks return before cpu resumes
package isc_pkg;
	localparam int unsigned CLK_HZ            = 10_000_000;
	localparam logic [7:0]  PSC_RST           = 8'h00;
	localparam logic [7:0]  POWER_SAVE_MODE_REG_RST          = 8'h00;
	localparam logic [7:0]  STABILIZATION_TIME_SELECT_RST          = 8'h06;
	localparam logic [7:0]  PSC_MASK          = 8'h72;
	localparam logic [7:0]  POWER_SAVE_MODE_REG_MASK         = 8'h03;
	localparam logic [7:0]  STABILIZATION_TIME_SELECT_MASK         = 8'h07;
	localparam int          PSC_WDT_M         = 6;
	localparam int          PSC_PIN_M         = 5;
	localparam int          PSC_INT_M         = 4;
	localparam int          PSC_STP           = 1;
	localparam logic [1:0]  SEL_LIGHT         = 2'b00;
	localparam logic [1:0]  SEL_DEEP          = 2'b10;
	localparam int          STAB_W            = 18;
	localparam int          STABILIZATION_TIME_SELECT_SHIFT_BASE   = 10;
	localparam int          RESET_STAB_CYCLES = 65536;
	localparam int          EXT_IRQ_N         = 11;
	localparam int          EXT_IRQ_FILT      = 3;
	localparam logic [2:0]  NF_SLOW_MIN       = 3'h3;
	localparam int          PRIO_W            = 3;
	typedef enum logic [1:0]
	{
		ST_RST_WAIT = 2'b00,
		ST_NORMAL   = 2'b01,
		ST_IDLE     = 2'b11,
		ST_STAB     = 2'b10
	} isc_state_type;
endpackage : isc_pkg

/* File: logic/isc_ctrl.sv */
`timescale 1ns/1ps
module isc_ctrl
#(
	parameter int RESET_STAB_CYCLES = isc_pkg::RESET_STAB_CYCLES,
	parameter int STABILIZATION_TIME_SELECT_SHIFT_BASE   = isc_pkg::STABILIZATION_TIME_SELECT_SHIFT_BASE
)
(
	input  wire logic                          clk,
	input  wire logic                          rstn,
	input  wire logic                          reset_req,
	input  wire logic                          prot_cmd_wr,
	input  wire logic                          psc_wr,
	input  wire logic                          power_save_mode_reg_wr,
	input  wire logic                          stabilization_time_select_wr,
	input  wire logic [7:0]                    wr_data,
	output logic      [7:0]                    power_save_control_reg,
	output logic      [7:0]                    power_save_mode_reg,
	output logic      [7:0]                    stabilization_time_select,
	input  wire logic                          nmi_pin_req,
	input  wire logic                          watchdog_nmi_request,
	input  wire logic [isc_pkg::EXT_IRQ_N-1:0] external_irq_inputs,
	input  wire logic                          periph_irq_req,
	input  wire logic [2:0]                    noise_filter_control,
	input  wire logic                          isr_active,
	input  wire logic [isc_pkg::PRIO_W-1:0]    isr_prio,
	input  wire logic [isc_pkg::PRIO_W-1:0]    irq_prio,
	input  wire logic                          int_enable,
	input  wire logic                          pll_enable_req,
	input  wire logic                          watch_src_ok,
	input  wire logic                          interval_src_ok,
	input  wire logic [1:0]                    serial_ext_clock_in,
	input  wire logic                          async_port_ext_clock,
	output logic                               cpu_clk_en,
	output logic                               periph_clk_en,
	output logic                               osc_run,
	output logic                               pll_run,
	output logic                               flash_run,
	output logic                               dma_run,
	output logic                               timer_run,
	output logic                               intc_run,
	output logic                               adc_hold,
	output logic                               port_hold,
	output logic                               wdt_run,
	output logic                               key_int_run,
	output logic                               subclk_periph_run,
	output logic                               watch_timer_run,
	output logic                               interval_timer_run,
	output logic      [1:0]                    clocked_serial_ports,
	output logic                               async_serial_port_zero,
	output logic                               light_idle_mode,
	output logic                               deep_idle_mode,
	output logic                               stop_mode_req,
	output logic                               wake_ack,
	output logic                               wake_vector,
	output logic                               wake_next_instr
);
	import isc_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	isc_state_type     state;
	isc_state_type     next_state;
	logic              armed;
	logic              idle_deep;
	logic              pll_saved;
	logic [STAB_W-1:0] stab_cnt;
	logic [STAB_W-1:0] next_stab_cnt;
	logic              kind_vector;
	logic              kind_ack;

	// ---------------------------------------------------------------
	// protected writes
	// ---------------------------------------------------------------
	wire psc_take  = psc_wr & armed;  // RULE22
	wire any_wr    = psc_wr | power_save_mode_reg_wr | stabilization_time_select_wr;
	wire [1:0] sel = {power_save_mode_reg[1], power_save_mode_reg[0]};
	wire stp_set   = psc_take & wr_data[PSC_STP] & (state == ST_NORMAL);
	wire go_light  = stp_set & (sel == SEL_LIGHT);  // RULE1
	wire go_deep   = stp_set & (sel == SEL_DEEP);  // RULE2
	wire go_stop   = stp_set & sel[0];  // RULE23

	// ---------------------------------------------------------------
	// wake qualification
	// ---------------------------------------------------------------
	wire filt_slow = noise_filter_control >= NF_SLOW_MIN;
	logic [EXT_IRQ_N-1:0] ext_ok;
	genvar gi;
	generate
		for (gi = 0; gi < EXT_IRQ_N; gi = gi + 1)
		begin : g_ext
			if (gi == EXT_IRQ_FILT)
			begin : g_filt
				assign ext_ok[gi] = external_irq_inputs[gi] & ~filt_slow;  // RULE10
			end
			else
			begin : g_plain
				assign ext_ok[gi] = external_irq_inputs[gi];
			end
		end
	endgenerate

	wire wake_nmi = (nmi_pin_req & ~power_save_control_reg[PSC_PIN_M])
		| (watchdog_nmi_request & ~power_save_control_reg[PSC_WDT_M]);  // RULE9
	wire wake_mask = ((|ext_ok) | periph_irq_req)
		& ~power_save_control_reg[PSC_INT_M];  // RULE9
	wire wake_any = wake_nmi | wake_mask;  // RULE8
	wire higher   = ~isr_active | (irq_prio < isr_prio);  // RULE11 RULE12
	wire do_vec   = wake_nmi | (wake_mask & int_enable & higher);  // RULE13
	wire do_ack   = wake_nmi | (wake_mask & higher);  // RULE12

	// ---------------------------------------------------------------
	// stabilization timer
	// ---------------------------------------------------------------
	wire [4:0] stabilization_time_select_shift = 5'(STABILIZATION_TIME_SELECT_SHIFT_BASE)
		+ {2'b00, stabilization_time_select[2:0]};
	wire [STAB_W-1:0] stabilization_time_select_len = STAB_W'((32'd1 << stabilization_time_select_shift) - 32'd1);
	wire [STAB_W-1:0] rst_len  = STAB_W'(RESET_STAB_CYCLES - 1);
	wire stab_done = stab_cnt == '0;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		next_state    = state;
		next_stab_cnt = stab_done ? stab_cnt : stab_cnt - 1'b1;
		case (state)
			ST_RST_WAIT:
			begin
				if (stab_done)
					next_state = ST_NORMAL;  // RULE15
			end
			ST_NORMAL:
			begin
				if (go_light | go_deep)
					next_state = ST_IDLE;
			end
			ST_IDLE:
			begin
				// a request already pending leaves on the next edge
				if (wake_any & idle_deep)  // RULE7
				begin
					next_state    = ST_STAB;  // RULE14
					next_stab_cnt = stabilization_time_select_len;
				end
				else if (wake_any)
					next_state = ST_NORMAL;  // RULE6 RULE24
			end
			ST_STAB:
			begin
				if (stab_done)
					next_state = ST_NORMAL;  // RULE14
			end
			default:
			begin
				next_state = ST_RST_WAIT;
			end
		endcase
	end

	wire leaving = (state == ST_IDLE & wake_any & ~idle_deep)
		| (state == ST_STAB & stab_done);

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state    <= ST_RST_WAIT;
			stab_cnt <= STAB_W'(RESET_STAB_CYCLES - 1);
		end
		else if (reset_req)
		begin
			state    <= ST_RST_WAIT;  // RULE8 RULE15
			stab_cnt <= rst_len;
		end
		else
		begin
			state    <= next_state;
			stab_cnt <= next_stab_cnt;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			armed <= 1'b0;
		else if (reset_req)
			armed <= 1'b0;
		else if (prot_cmd_wr)
			armed <= 1'b1;  // RULE22
		else if (any_wr)
			armed <= 1'b0;  // RULE22
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			power_save_control_reg <= PSC_RST;  // RULE23
		else if (reset_req)
			power_save_control_reg <= PSC_RST;
		else if (psc_take)
			power_save_control_reg <= wr_data & PSC_MASK;  // RULE22
		else if (leaving | go_stop)
			power_save_control_reg[PSC_STP] <= 1'b0;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			power_save_mode_reg <= POWER_SAVE_MODE_REG_RST;  // RULE23
		else if (reset_req)
			power_save_mode_reg <= POWER_SAVE_MODE_REG_RST;
		else if (power_save_mode_reg_wr)
			power_save_mode_reg <= wr_data & POWER_SAVE_MODE_REG_MASK;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			stabilization_time_select <= STABILIZATION_TIME_SELECT_RST;
		else if (reset_req)
			stabilization_time_select <= STABILIZATION_TIME_SELECT_RST;
		else if (stabilization_time_select_wr)
			stabilization_time_select <= wr_data & STABILIZATION_TIME_SELECT_MASK;
	end

	// mode and pll state captured on entry
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			idle_deep <= 1'b0;
			pll_saved <= 1'b0;
		end
		else if (go_light | go_deep)
		begin
			idle_deep <= go_deep;
			pll_saved <= pll_enable_req;  // RULE16
		end
	end

	// wake classification, held across the deep wait
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			kind_vector <= 1'b0;
			kind_ack    <= 1'b0;
		end
		else if (state == ST_IDLE & wake_any)
		begin
			kind_vector <= do_vec;  // RULE13
			kind_ack    <= do_ack;  // RULE11 RULE12
		end
	end

	// resume pulses issued with the clocks coming back
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wake_ack        <= 1'b0;
			wake_vector     <= 1'b0;
			wake_next_instr <= 1'b0;
			stop_mode_req   <= 1'b0;
		end
		else
		begin
			wake_ack        <= leaving & ~reset_req
				& (idle_deep ? kind_ack : do_ack);  // RULE11 RULE12
			wake_vector     <= leaving & ~reset_req
				& (idle_deep ? kind_vector : do_vec);  // RULE13
			wake_next_instr <= leaving & ~reset_req
				& ~(idle_deep ? kind_vector : do_vec);  // RULE13
			stop_mode_req   <= go_stop & ~reset_req;  // RULE23
		end
	end

	// ---------------------------------------------------------------
	// clock gating and peripheral status
	// ---------------------------------------------------------------
	wire in_idle  = state == ST_IDLE;
	wire in_stab  = state == ST_STAB;
	wire stopped  = in_idle | in_stab;
	wire deep_off = in_idle & idle_deep;
	wire normal   = state == ST_NORMAL;

	assign cpu_clk_en        = normal;  // RULE3 RULE4 RULE24
	assign periph_clk_en     = normal;  // RULE3 RULE4 RULE24
	assign osc_run           = 1'b1;  // RULE3 RULE4
	assign pll_run           = deep_off ? 1'b0 :
		(stopped ? pll_saved : pll_enable_req);  // RULE4 RULE16
	assign flash_run         = ~deep_off;  // RULE3 RULE4
	assign dma_run           = ~stopped;  // RULE18
	assign timer_run         = ~stopped;  // RULE18
	assign intc_run          = ~stopped;  // RULE18
	assign adc_hold          = stopped;  // RULE17
	assign port_hold         = stopped;  // RULE18
	assign wdt_run           = 1'b1;  // RULE18
	assign key_int_run       = 1'b1;  // RULE18
	assign subclk_periph_run = 1'b1;  // RULE5
	assign watch_timer_run   = ~stopped | watch_src_ok;  // RULE19
	assign interval_timer_run = ~stopped | interval_src_ok;  // RULE19
	assign clocked_serial_ports = stopped ? serial_ext_clock_in
		: 2'b11;  // RULE20
	assign async_serial_port_zero = ~stopped
		| async_port_ext_clock;  // RULE20
	assign light_idle_mode   = in_idle & ~idle_deep;
	assign deep_idle_mode    = stopped & idle_deep;

endmodule : isc_ctrl

/* File: tb/isc_ctrl_asserts.sv */
`timescale 1ns/1ps
module isc_ctrl_asserts
(
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic       reset_req,
	input wire logic       prot_cmd_wr,
	input wire logic       psc_wr,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] power_save_control_reg,
	input wire logic [7:0] power_save_mode_reg,
	input wire logic       nmi_pin_req,
	input wire logic       watchdog_nmi_request,
	input wire logic [isc_pkg::EXT_IRQ_N-1:0] external_irq_inputs,
	input wire logic       periph_irq_req,
	input wire logic [2:0] noise_filter_control,
	input wire logic       cpu_clk_en,
	input wire logic       pll_run,
	input wire logic       flash_run,
	input wire logic       adc_hold,
	input wire logic       port_hold,
	input wire logic       light_idle_mode,
	input wire logic       deep_idle_mode,
	input wire logic       stop_mode_req,
	input wire logic       wake_vector,
	input wire logic       wake_next_instr
);
	import isc_pkg::*;
	logic                 armed;
	logic                 go;
	logic                 wk;
	logic [EXT_IRQ_N-1:0] ext_live;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// ------------------------------
	// armed write and wake qualifier
	// ------------------------------
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			armed <= 1'b0;
		else
			armed <= ~reset_req & (prot_cmd_wr | (armed & ~psc_wr));
	assign ext_live = external_irq_inputs
		& ~(EXT_IRQ_N'(noise_filter_control >= NF_SLOW_MIN) << EXT_IRQ_FILT);
	assign wk = nmi_pin_req & ~power_save_control_reg[PSC_PIN_M]
		| watchdog_nmi_request & ~power_save_control_reg[PSC_WDT_M]
		| (|ext_live | periph_irq_req) & ~power_save_control_reg[PSC_INT_M];
	assign go = armed & psc_wr & wr_data[PSC_STP] & cpu_clk_en & ~reset_req;
	sequence enter_s(logic [1:0] sel);
		go && power_save_mode_reg[1:0] == sel;
	endsequence
	sequence wake_s;
		wk && !reset_req;
	endsequence
	light_entry_a:
	assert property (enter_s(SEL_LIGHT) |=> light_idle_mode && flash_run)
		else $error("light idle not entered");
	deep_entry_a:
	assert property (enter_s(SEL_DEEP) |=> deep_idle_mode && !flash_run && !pll_run)
		else $error("deep idle not entered");
	stop_entry_a:
	assert property (go && power_save_mode_reg[0] |=> stop_mode_req && !light_idle_mode)
		else $error("stop request missing");
	keep_alive_a:
	assert property (light_idle_mode || deep_idle_mode |-> adc_hold && port_hold && !cpu_clk_en)
		else $error("idle outputs wrong");
	light_wake_a:
	assert property (light_idle_mode ##0 wake_s |=> cpu_clk_en && !light_idle_mode)
		else $error("light wake late");
	idle_hold_a:
	assert property (light_idle_mode && !wk && !reset_req |=> light_idle_mode)
		else $error("idle left without cause");
	deep_wait_a:
	assert property (deep_idle_mode && !flash_run ##0 wake_s |=> (!cpu_clk_en && deep_idle_mode)[*3])
		else $error("deep wake too early");
	unarmed_a:
	assert property (psc_wr && !armed && cpu_clk_en && !reset_req |=> $stable(power_save_control_reg))
		else $error("unarmed write took effect");
	reset_req_a:
	assert property (reset_req |=> !cpu_clk_en && power_save_control_reg == PSC_RST)
		else $error("reset request ignored");
	wake_kind_a:
	assert property (wake_vector || wake_next_instr |-> $rose(cpu_clk_en) && wake_vector != wake_next_instr)
		else $error("wake outcome wrong");
endmodule : isc_ctrl_asserts
bind isc_ctrl isc_ctrl_asserts isc_ctrl_asserts_i
(
	.clk, .rstn, .reset_req, .prot_cmd_wr, .psc_wr, .wr_data,
	.power_save_control_reg, .power_save_mode_reg, .nmi_pin_req,
	.watchdog_nmi_request, .external_irq_inputs, .periph_irq_req,
	.noise_filter_control, .cpu_clk_en, .pll_run, .flash_run, .adc_hold,
	.port_hold, .light_idle_mode, .deep_idle_mode, .stop_mode_req,
	.wake_vector, .wake_next_instr
);

/* File: tb/isc_cpu_model.sv */
`timescale 1ns/1ps
module isc_cpu_model
(
	input wire logic   clk,
	output logic       prot_cmd_wr,
	output logic       psc_wr,
	output logic       power_save_mode_reg_wr,
	output logic       stabilization_time_select_wr,
	output logic [7:0] wr_data
);
	int nop_left = 0;
	initial
	begin
		{prot_cmd_wr, psc_wr, power_save_mode_reg_wr, stabilization_time_select_wr} = 4'h0;
		wr_data = 8'h5a;
	end
	// kind 0 control, 1 mode, 2 wait select; gap idles after the command
	task automatic write_reg(input int kind, input logic [7:0] data,
		input bit prot, input int gap);
		while (nop_left > 0)
		begin
			@(negedge clk);
			nop_left--;
		end
		@(negedge clk);
		if (prot)
		begin
			prot_cmd_wr = 1'b1;
			@(negedge clk);
			prot_cmd_wr = 1'b0;
			repeat (gap) @(negedge clk);
		end
		wr_data = data;
		psc_wr = (kind == 0);
		power_save_mode_reg_wr = (kind == 1);
		stabilization_time_select_wr = (kind == 2);
		@(negedge clk);
		{psc_wr, power_save_mode_reg_wr, stabilization_time_select_wr} = 3'h0;
		wr_data = ~data;
		nop_left = (kind == 0) ? 5 : 0;
	endtask : write_reg
endmodule : isc_cpu_model

/* File: tb/isc_ctrl_bench.sv */
`timescale 1ns/1ps
module isc_ctrl_bench;
	import isc_pkg::*;
	localparam int RST_N = 16;
	localparam int BASE = 2;
	logic clk, rstn, reset_req, prot_cmd_wr, psc_wr, power_save_mode_reg_wr, stabilization_time_select_wr;
	logic nmi_pin_req, watchdog_nmi_request, periph_irq_req, isr_active;
	logic int_enable, pll_enable_req, watch_src_ok, interval_src_ok;
	logic async_port_ext_clock, cpu_clk_en, pll_run, flash_run, blk;
	logic light_idle_mode, deep_idle_mode, stop_mode_req, wake_ack;
	logic wake_vector, wake_next_instr;
	logic [1:0] serial_ext_clock_in;
	logic [2:0] noise_filter_control, isr_prio, irq_prio;
	logic [7:0] wr_data, power_save_control_reg, power_save_mode_reg;
	logic [7:0] stabilization_time_select;
	logic [EXT_IRQ_N-1:0] external_irq_inputs;
	int n_errors = 0;
	int n_checks = 0;
	int irq_idx, k, mbit;
	isc_ctrl #(.RESET_STAB_CYCLES(RST_N), .STABILIZATION_TIME_SELECT_SHIFT_BASE(BASE)) isc_ctrl_i
	(
		.clk, .rstn, .reset_req, .prot_cmd_wr, .psc_wr, .power_save_mode_reg_wr, .stabilization_time_select_wr,
		.wr_data, .power_save_control_reg, .power_save_mode_reg,
		.stabilization_time_select, .nmi_pin_req, .watchdog_nmi_request,
		.external_irq_inputs, .periph_irq_req, .noise_filter_control,
		.isr_active, .isr_prio, .irq_prio, .int_enable, .pll_enable_req,
		.watch_src_ok, .interval_src_ok, .serial_ext_clock_in,
		.async_port_ext_clock, .cpu_clk_en, .periph_clk_en(), .osc_run(),
		.pll_run, .flash_run, .dma_run(), .timer_run(), .intc_run(),
		.adc_hold(), .port_hold(), .wdt_run(), .key_int_run(),
		.subclk_periph_run(), .watch_timer_run(), .interval_timer_run(),
		.clocked_serial_ports(), .async_serial_port_zero(),
		.light_idle_mode, .deep_idle_mode, .stop_mode_req, .wake_ack,
		.wake_vector, .wake_next_instr
	);
	isc_cpu_model isc_cpu_model_i
	(
		.clk, .prot_cmd_wr, .psc_wr, .power_save_mode_reg_wr, .stabilization_time_select_wr, .wr_data
	);
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ----------------
	// checks and waits
	// ----------------
	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	task automatic wait_run(output int cnt);
		cnt = 0;
		while (cpu_clk_en !== 1'b1)
		begin
			@(negedge clk);
			cnt++;
			if (cnt > 2000)
			begin
				n_errors++;
				$display("MISMATCH wait_run expected run seen timeout");
				final_report();
			end
		end
	endtask : wait_run
	task automatic raise(input int kind, input logic v);
		case (kind)
			0: nmi_pin_req = v;
			1: watchdog_nmi_request = v;
			2: external_irq_inputs[irq_idx] = v;
			3: periph_irq_req = v;
			default: external_irq_inputs[EXT_IRQ_FILT] = v;
		endcase
	endtask : raise
	// ack, vector, next instruction
	function automatic logic [2:0] exp_wake(input int kind);
		logic hi;
		logic vec;
		hi = !isr_active || irq_prio < isr_prio;
		vec = kind < 2 || int_enable && hi;
		return {kind < 2 || hi, vec, !vec};
	endfunction : exp_wake
	// --------------
	// main sequence
	// --------------
	initial
	begin
		k = $urandom(73925);
		{rstn, reset_req, nmi_pin_req, watchdog_nmi_request} = 4'h0;
		periph_irq_req = 1'b0;
		external_irq_inputs = '0;
		{isr_active, int_enable, pll_enable_req, watch_src_ok, interval_src_ok,
			async_port_ext_clock, serial_ext_clock_in, noise_filter_control,
			isr_prio, irq_prio} = 17'($urandom);
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		check("ctl reset", 8'h00, power_save_control_reg);
		check("mode reset", 8'h00, power_save_mode_reg);
		check("wait reset", 8'h06, stabilization_time_select);
		wait_run(k);
		check("reset wait", 8'h01, 8'(k >= RST_N && k <= RST_N + 1));
		isc_cpu_model_i.write_reg(0, 8'h02, 1'b0, 0);
		check("unarmed", 8'h01, 8'(cpu_clk_en & ~light_idle_mode));
		for (int kind = 0; kind < 5; kind++)
			for (int m = 0; m < 2; m++)
			begin
				{isr_active, int_enable, pll_enable_req, isr_prio,
					irq_prio} = 9'($urandom);
				noise_filter_control = (kind == 4) ? 3'(3 + $urandom_range(4))
					: 3'($urandom);
				irq_idx = $urandom_range(9);
				irq_idx = (irq_idx >= 3) ? irq_idx + 1 : irq_idx;
				mbit = (kind == 0) ? PSC_PIN_M : (kind == 1) ? PSC_WDT_M : PSC_INT_M;
				blk = m || kind == 4;
				isc_cpu_model_i.write_reg(0, 8'h02 | (m ? 8'(1 << mbit) : 8'h00),
					1'b1, $urandom_range(3));
				check("light", 8'h01, 8'(light_idle_mode & flash_run));
				check("pll kept", 8'(pll_enable_req), 8'(pll_run));
				raise(kind, 1'b1);
				repeat (blk ? 3 : 1) @(negedge clk);
				check("woken", 8'(!blk), 8'(cpu_clk_en));
				if (blk)
				begin
					reset_req = 1'b1;
					@(negedge clk);
					reset_req = 1'b0;
					check("reset req", 8'h00, power_save_control_reg);
				end
				else
					check("wake", 8'(exp_wake(kind)),
						8'({wake_ack, wake_vector, wake_next_instr}));
				raise(kind, 1'b0);
				wait_run(k);
			end
		periph_irq_req = 1'b1;
		isc_cpu_model_i.write_reg(0, 8'h02, 1'b1, 0);
		check("pending in", 8'(light_idle_mode), 8'h01);
		@(negedge clk);
		check("pending out", 8'(cpu_clk_en), 8'h01);
		periph_irq_req = 1'b0;
		isc_cpu_model_i.write_reg(1, 8'h02, 1'b0, 0);
		for (int s = 0; s < 3; s++)
		begin
			pll_enable_req = 1'($urandom);
			isc_cpu_model_i.write_reg(2, 8'(s), 1'b0, 0);
			isc_cpu_model_i.write_reg(0, 8'h02, 1'b1, s);
			check("deep", 8'h01, 8'(deep_idle_mode & ~flash_run & ~pll_run));
			nmi_pin_req = 1'b1;
			wait_run(k);
			nmi_pin_req = 1'b0;
			check("deep wait", 8'(2 ** (BASE + s) + 1), 8'(k));
			check("pll back", 8'(pll_enable_req), 8'(pll_run));
		end
		for (int s = 1; s < 4; s += 2)
		begin
			isc_cpu_model_i.write_reg(1, 8'(s), 1'b0, 0);
			isc_cpu_model_i.write_reg(0, 8'h02, 1'b1, 0);
			check("stop", 8'h01, 8'(stop_mode_req & ~light_idle_mode));
		end
		final_report();
	end
endmodule : isc_ctrl_bench
